// ---- rtcca_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtcca_top (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic crystal_clk_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [43:0] calendar_value_in,
  output logic [15:0] reg_rdata_out,
  output logic half_second_pulse_out,
  output logic seconds_pulse_out,
  output logic alarm_pulse_out,
  output logic irq_out
);
  // released reset copy
  logic [1:0] rst_sync;
  logic rst_n;
  // crystal sampling, first stage feeds second only
  logic [2:0] xtal_sync;
  logic tick;
  // calibration state
  logic timer_on, next_timer_on;
  logic [7:0] trim, next_trim;
  logic [7:0] trim_abs;
  logic [9:0] trim_x4;
  // timebase state
  logic [14:0] pre, next_pre;
  logic [9:0] stall, next_stall;
  logic [5:0] sec, next_sec;
  logic sec_p, next_sec_p;
  logic half_p, next_half_p;
  logic min_p, next_min_p;
  logic window;
  // alarm state
  logic alm_en, next_alm_en;
  logic endless, next_endless;
  logic [3:0] mask, next_mask;
  logic [7:0] rpt, next_rpt;
  logic [43:0] cmp, next_cmp;
  logic alm_pulse, next_alm_pulse;
  logic half_d, sec_d;
  logic [10:0] dig_eq;
  logic match, eval, alarm_event;
  // interrupt state
  logic [2:0] irq_stat, next_irq_stat;
  logic [2:0] irq_en, next_irq_en;
  logic [2:0] irq_ev;
  logic [15:0] next_rdata;
  // write decodes
  logic wr_cal, wr_cfg, wr_v0, wr_v1, wr_v2, wr_clr, wr_ien;

  assign wr_cal = reg_write_in && (reg_addr_in == rtcca_pkg::OFS_CAL);
  assign wr_cfg = reg_write_in && (reg_addr_in == rtcca_pkg::OFS_ALM_CFG);
  assign wr_v0 = reg_write_in && (reg_addr_in == rtcca_pkg::OFS_ALM_V0);
  assign wr_v1 = reg_write_in && (reg_addr_in == rtcca_pkg::OFS_ALM_V1);
  assign wr_v2 = reg_write_in && (reg_addr_in == rtcca_pkg::OFS_ALM_V2);
  assign wr_clr = reg_write_in && (reg_addr_in == rtcca_pkg::OFS_IRQ_CLR);
  assign wr_ien = reg_write_in && (reg_addr_in == rtcca_pkg::OFS_IRQ_EN);

  // reset release through two flops
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rst_sync <= '0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // crystal pin synchroniser plus edge stage
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      xtal_sync <= '0;
    else
      xtal_sync <= {xtal_sync[1:0], crystal_clk_in};
  end
  // one crystal pulse per rising edge
  assign tick = xtal_sync[1] & ~xtal_sync[2];

  // trim magnitude scaled by four
  assign trim_abs = trim[rtcca_pkg::TRIM_W-1] ? (~trim + 8'h01) : trim;
  assign trim_x4 = {trim_abs, 2'b00};
  // near seconds rollover the calendar is about to change
  assign window = (pre >= rtcca_pkg::WINDOW_START);

  // timebase next state with minute correction
  always_comb
  begin
    next_timer_on = timer_on;
    next_trim = trim;
    next_pre = pre;
    next_stall = stall;
    next_sec = sec;
    next_sec_p = 1'b0;
    next_half_p = 1'b0;
    next_min_p = 1'b0;
    if (wr_cal)
    begin
      next_timer_on = reg_wdata_in[rtcca_pkg::TIMER_ON_BIT];
      next_trim = reg_wdata_in[rtcca_pkg::TRIM_W-1:0];
    end
    if (timer_on && tick)
    begin
      if (stall != '0)
        next_stall = stall - 10'h001;
      else if (pre == rtcca_pkg::PRE_HALF)
      begin
        next_pre = pre + 15'h0001;
        next_half_p = 1'b1;
      end
      else if (pre == rtcca_pkg::PRE_TOP)
      begin
        next_sec_p = 1'b1;
        next_half_p = 1'b1;
        if (sec == rtcca_pkg::SEC_TOP)
        begin
          // minute boundary: apply trim
          next_sec = '0;
          next_min_p = 1'b1;
          if (trim[rtcca_pkg::TRIM_W-1])
          begin
            next_pre = '0;
            next_stall = trim_x4;
          end
          else
            next_pre = {5'h00, trim_x4};
        end
        else
        begin
          next_sec = sec + 6'h01;
          next_pre = '0;
        end
      end
      else
        next_pre = pre + 15'h0001;
    end
  end

  // timebase registers
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_on <= 1'b0;
      trim <= '0;
      pre <= '0;
      stall <= '0;
      sec <= '0;
      sec_p <= 1'b0;
      half_p <= 1'b0;
      min_p <= 1'b0;
    end
    else
    begin
      timer_on <= next_timer_on;
      trim <= next_trim;
      pre <= next_pre;
      stall <= next_stall;
      sec <= next_sec;
      sec_p <= next_sec_p;
      half_p <= next_half_p;
      min_p <= next_min_p;
    end
  end

  // per digit compare against the calendar
  genvar gi;
  generate
    for (gi = 0; gi < rtcca_pkg::DIG_N; gi++)
    begin : g_dig
      assign dig_eq[gi] = (cmp[gi*4 +: 4] == calendar_value_in[gi*4 +: 4]);
    end
  endgenerate
  // selected digits all equal, reserved codes never match
  assign match = (mask <= rtcca_pkg::MASK_MAX) &&
                 (&(dig_eq | ~rtcca_pkg::MASK_DIGITS[mask]));
  // evaluate one cycle after the calendar steps
  assign eval = (mask == rtcca_pkg::MASK_HALF) ? half_d : sec_d;
  assign alarm_event = alm_en && eval && match;

  // alarm next state, software write wins
  always_comb
  begin
    next_alm_en = alm_en;
    next_endless = endless;
    next_mask = mask;
    next_rpt = rpt;
    next_cmp = cmp;
    next_alm_pulse = alm_pulse;
    if (alarm_event)
    begin
      next_alm_pulse = ~alm_pulse;
      if (rpt != rtcca_pkg::RPT_ZERO)
        next_rpt = rpt - 8'h01;
      else if (endless)
        next_rpt = rtcca_pkg::RPT_WRAP;
      else
        next_alm_en = 1'b0;
    end
    if (wr_cfg)
    begin
      next_alm_en = reg_wdata_in[rtcca_pkg::ALM_EN_BIT];
      next_endless = reg_wdata_in[rtcca_pkg::ENDLESS_BIT];
      next_mask = reg_wdata_in[rtcca_pkg::MASK_HI:rtcca_pkg::MASK_LO];
      next_rpt = reg_wdata_in[rtcca_pkg::RPT_W-1:0];
    end
    // compare value words
    if (wr_v0)
      next_cmp[15:0] = reg_wdata_in;
    if (wr_v1)
      next_cmp[31:16] = reg_wdata_in;
    if (wr_v2)
      next_cmp[43:32] = reg_wdata_in[11:0];
  end

  // alarm registers
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alm_en <= 1'b0;
      endless <= 1'b0;
      mask <= '0;
      rpt <= '0;
      cmp <= '0;
      alm_pulse <= 1'b0;
      half_d <= 1'b0;
      sec_d <= 1'b0;
    end
    else
    begin
      alm_en <= next_alm_en;
      endless <= next_endless;
      mask <= next_mask;
      rpt <= next_rpt;
      cmp <= next_cmp;
      alm_pulse <= next_alm_pulse;
      half_d <= half_p;
      sec_d <= sec_p;
    end
  end

  // sticky status, set wins over clear; readback mux
  assign irq_ev = {min_p, sec_p, alarm_event};
  always_comb
  begin
    next_irq_en = irq_en;
    next_irq_stat = irq_stat & ~(wr_clr ? reg_wdata_in[2:0] : 3'h0);
    next_irq_stat = next_irq_stat | irq_ev;
    if (wr_ien)
      next_irq_en = reg_wdata_in[2:0];
    next_rdata = '0;
    if (reg_read_in)
    begin
      unique case (reg_addr_in)
        rtcca_pkg::OFS_CAL:
        begin
          next_rdata[rtcca_pkg::TRIM_W-1:0] = trim;
          next_rdata[rtcca_pkg::WINDOW_BIT] = window;
          next_rdata[rtcca_pkg::TIMER_ON_BIT] = timer_on;
        end
        rtcca_pkg::OFS_ALM_CFG:
        begin
          next_rdata[rtcca_pkg::RPT_W-1:0] = rpt;
          next_rdata[rtcca_pkg::MASK_HI:rtcca_pkg::MASK_LO] = mask;
          next_rdata[rtcca_pkg::ENDLESS_BIT] = endless;
          next_rdata[rtcca_pkg::ALM_EN_BIT] = alm_en;
        end
        rtcca_pkg::OFS_ALM_V0: next_rdata = cmp[15:0];
        rtcca_pkg::OFS_ALM_V1: next_rdata = cmp[31:16];
        rtcca_pkg::OFS_ALM_V2: next_rdata[11:0] = cmp[43:32];
        rtcca_pkg::OFS_IRQ_STAT: next_rdata[2:0] = irq_stat;
        rtcca_pkg::OFS_IRQ_EN: next_rdata[2:0] = irq_en;
        default: next_rdata = '0; // unmapped and clear register read zero
      endcase
    end
  end

  // interrupt and read data registers
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat <= '0;
      irq_en <= '0;
      reg_rdata_out <= '0;
    end
    else
    begin
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
      reg_rdata_out <= next_rdata;
    end
  end

  assign irq_out = |(irq_stat & irq_en);
  assign half_second_pulse_out = half_p;
  assign seconds_pulse_out = sec_p;
  assign alarm_pulse_out = alm_pulse;

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_minute_edge;
    timer_on && tick && (stall == '0) && (pre == rtcca_pkg::PRE_TOP) &&
    (sec == rtcca_pkg::SEC_TOP) && !wr_cal;
  endsequence
  sequence s_last_alarm;
    alarm_event && (rpt == rtcca_pkg::RPT_ZERO) && !endless && !wr_cfg;
  endsequence

  a_trim_add: assert property (s_minute_edge and !trim[7] |=>
    (pre == {5'h00, $past(trim_x4)}) && min_p && (stall == '0))
    else $error("positive trim not loaded at minute");
  a_trim_remove: assert property (s_minute_edge and trim[7] |=>
    (stall == $past(trim_x4)) && (pre == '0))
    else $error("negative trim not held at minute");
  a_last_alarm_off: assert property (s_last_alarm |=> !alm_en ##1 !alarm_event)
    else $error("alarm stays on after final alarm");
  a_repeat_count: assert property (alarm_event && (rpt != 8'h00) && !wr_cfg |=>
    alm_en && (rpt == $past(rpt) - 8'h01))
    else $error("repeat count not decremented");
  a_endless_wrap: assert property (alarm_event && (rpt == 8'h00) && endless && !wr_cfg |=>
    alm_en && (rpt == 8'hff))
    else $error("endless repeat did not wrap");
  a_alarm_irq: assert property (alarm_event |=> irq_stat[0] && (irq_en[0] -> irq_out))
    else $error("alarm did not raise interrupt");
  a_pulse_toggle: assert property (alarm_event |=> alarm_pulse_out != $past(alarm_pulse_out))
    else $error("alarm pulse did not toggle");
  a_pulse_hold: assert property (!alarm_event |=> $stable(alarm_pulse_out))
    else $error("alarm pulse moved without alarm");
  // ten second mask: sec ones digit alone decides, checked without the mask table
  a_match_alarm: assert property (alm_en && sec_d && (mask == 4'h2) &&
    (cmp[3:0] == calendar_value_in[3:0]) |-> alarm_event)
    else $error("matching digits did not alarm");
  // hardware never turns the alarm on and a disabled alarm never pulses
  a_disabled_quiet: assert property (!alm_en && !wr_cfg |=>
    !alm_en && $stable(alarm_pulse_out))
    else $error("alarm while disabled");
  a_half_interval: assert property (alarm_event && mask == 4'h0 |-> $past(half_p))
    else $error("half second alarm off its pulse");
endmodule
`default_nettype wire

// ---- rtcca_pkg.sv ----
`default_nettype none
package rtcca_pkg;
  // register bus shape
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;
  // register offsets
  localparam logic [3:0] OFS_CAL = 4'h0;
  localparam logic [3:0] OFS_ALM_CFG = 4'h1;
  localparam logic [3:0] OFS_ALM_V0 = 4'h2;
  localparam logic [3:0] OFS_ALM_V1 = 4'h3;
  localparam logic [3:0] OFS_ALM_V2 = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h5;
  localparam logic [3:0] OFS_IRQ_CLR = 4'h6;
  localparam logic [3:0] OFS_IRQ_EN = 4'h7;
  // calibration register fields
  localparam int unsigned TRIM_W = 8;
  localparam int unsigned TIMER_ON_BIT = 15;
  localparam int unsigned WINDOW_BIT = 12;
  localparam int unsigned CORR_W = 10;
  // alarm configuration fields
  localparam int unsigned ALM_EN_BIT = 15;
  localparam int unsigned ENDLESS_BIT = 14;
  localparam int unsigned MASK_HI = 13;
  localparam int unsigned MASK_LO = 10;
  localparam int unsigned RPT_W = 8;
  localparam logic [7:0] RPT_ZERO = 8'h00;
  localparam logic [7:0] RPT_WRAP = 8'hff;
  // timebase: 32768 crystal pulses per second
  localparam int unsigned PRE_W = 15;
  localparam logic [14:0] PRE_HALF = 15'h3fff;
  localparam logic [14:0] PRE_TOP = 15'h7fff;
  localparam logic [14:0] WINDOW_START = 15'h7fe0;
  localparam int unsigned SEC_W = 6;
  localparam logic [5:0] SEC_TOP = 6'h3b;
  // interrupt sources
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_ALARM = 0;
  localparam int unsigned IRQ_SEC = 1;
  localparam int unsigned IRQ_TRIM = 2;
  // calendar digits: sec1 sec10 min1 min10 hr1 hr10 wday day1 day10 mon1 mon10
  localparam int unsigned DIG_N = 11;
  localparam int unsigned CAL_W = 44;
  // mask codes, half second up to one year
  localparam logic [3:0] MASK_HALF = 4'h0;
  localparam logic [3:0] MASK_MAX = 4'h9;
  // digits that must match for each mask code
  localparam logic [10:0] MASK_DIGITS [16] = '{
    11'h000, 11'h000, 11'h001, 11'h003, 11'h007, 11'h00f, 11'h03f, 11'h07f,
    11'h1bf, 11'h7bf, 11'h000, 11'h000, 11'h000, 11'h000, 11'h000, 11'h000};
endpackage
`default_nettype wire

// ---- test_rtc_calibration_and_alarm.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_rtc_calibration_and_alarm;
  // design inputs, all driven from time zero
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic crystal_clk_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_write_in = 1'b0;
  logic reg_read_in = 1'b0;
  logic [43:0] calendar_value_in = 44'h0;
  // design outputs
  logic [15:0] reg_rdata_out;
  logic half_second_pulse_out;
  logic seconds_pulse_out;
  logic alarm_pulse_out;
  logic irq_out;
  // score keeping
  int mismatches = 0;
  int n_compared = 0;
  // stimulus values
  logic [7:0] trim;
  logic [43:0] cmp;
  int seed_dummy;
  int waited;
  // measured crystal rate fed to the trim calculation
  int rate;
  // pulse counters, sampled away from the launching edge
  int n_half = 0;
  int n_sec = 0;

  // 25 mhz core clock
  always #20 core_clk_in = ~core_clk_in;

  // crystal stand-in runs as fast as the synchroniser allows, so a second lasts 65536 cycles
  always @(posedge core_clk_in) crystal_clk_in <= ~crystal_clk_in;

  // count the half second and seconds pulses
  always @(negedge core_clk_in)
  begin
    if (half_second_pulse_out === 1'b1)
      n_half++;
    if (seconds_pulse_out === 1'b1)
      n_sec++;
  end

  rtcca_top i_dut (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .crystal_clk_in(crystal_clk_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in),
    .calendar_value_in(calendar_value_in),
    .reg_rdata_out(reg_rdata_out),
    .half_second_pulse_out(half_second_pulse_out),
    .seconds_pulse_out(seconds_pulse_out),
    .alarm_pulse_out(alarm_pulse_out),
    .irq_out(irq_out)
  );

  // verdict and end of run
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // compare a register word
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // compare a single output line
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge core_clk_in);
    reg_write_in <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle only
  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge core_clk_in);
    reg_read_in <= 1'b0;
    @(negedge core_clk_in);
    chk16(reg_rdata_out, exp);
  endtask

  // bounded wait for the alarm pulse line to leave its old level
  task automatic wait_toggle(input logic was, output int n);
    n = 0;
    while (alarm_pulse_out === was && n < 40000)
    begin
      @(negedge core_clk_in);
      n++;
    end
    if (n >= 40000)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: alarm pulse stuck %h %h", $time, alarm_pulse_out, was);
      wrap_up();
    end
  endtask

  // trim as software derives it: ideal minus measured, per minute, over four
  function automatic logic [7:0] trim_from_rate(input int measured);
    int per_minute;
    per_minute = (32768 - measured) * 60;
    return 8'(per_minute / 4);
  endfunction

  // expected alarm configuration word
  function automatic logic [15:0] cfg_word(input logic en, input logic endl,
                                           input logic [3:0] m, input logic [7:0] c);
    logic [15:0] w;
    w = 16'h0000;
    w[rtcca_pkg::ALM_EN_BIT] = en;
    w[rtcca_pkg::ENDLESS_BIT] = endl;
    w[rtcca_pkg::MASK_HI:rtcca_pkg::MASK_LO] = m;
    w[7:0] = c;
    return w;
  endfunction

  // main sequence
  initial
  begin
    seed_dummy = $urandom(32'h5e95bf1a);
    repeat (16) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    // every index reads zero after reset, unmapped and write-only ones too
    for (int a = 0; a < 16; a++)
      rdchk(4'(a), 16'h0000);
    chk1(irq_out, 1'b0);
    chk1(alarm_pulse_out, 1'b0);
    // trim loaded while the timer is stopped; update window bit is read-only
    rate = 32760 + int'($urandom_range(16, 0));
    trim = trim_from_rate(rate);
    wr(rtcca_pkg::OFS_CAL, {3'h0, 1'b1, 4'h0, trim});
    rdchk(rtcca_pkg::OFS_CAL, {8'h00, trim});
    // compare value written while the alarm is off; sec ones digit is 5
    cmp = {12'($urandom), 32'($urandom)};
    cmp[3:0] = 4'h5;
    wr(rtcca_pkg::OFS_ALM_V0, cmp[15:0]);
    wr(rtcca_pkg::OFS_ALM_V1, cmp[31:16]);
    wr(rtcca_pkg::OFS_ALM_V2, {4'hf, cmp[43:32]});
    rdchk(rtcca_pkg::OFS_ALM_V0, cmp[15:0]);
    rdchk(rtcca_pkg::OFS_ALM_V1, cmp[31:16]);
    rdchk(rtcca_pkg::OFS_ALM_V2, {4'h0, cmp[43:32]});
    // no digit of the calendar matches yet
    @(posedge core_clk_in);
    calendar_value_in <= ~cmp;
    // half-second alarm, endless, count at zero
    wr(rtcca_pkg::OFS_ALM_CFG, cfg_word(1'b1, 1'b1, rtcca_pkg::MASK_HALF, rtcca_pkg::RPT_ZERO));
    wr(rtcca_pkg::OFS_CAL, {1'b1, 7'h00, trim});
    wait_toggle(1'b0, waited);
    chk1(waited >= 32760 && waited <= 32800, 1'b1);
    chk1(alarm_pulse_out, 1'b1);
    chk16(16'(n_half), 16'h0001);
    chk16(16'(n_sec), 16'h0000);
    rdchk(rtcca_pkg::OFS_ALM_CFG, cfg_word(1'b1, 1'b1, 4'h0, rtcca_pkg::RPT_WRAP));
    rdchk(rtcca_pkg::OFS_IRQ_STAT, 16'h0001);
    chk1(irq_out, 1'b0);
    // unmask, then clear the alarm interrupt
    wr(rtcca_pkg::OFS_IRQ_EN, 16'h0001);
    @(negedge core_clk_in);
    chk1(irq_out, 1'b1);
    wr(rtcca_pkg::OFS_IRQ_CLR, 16'h0001);
    @(negedge core_clk_in);
    chk1(irq_out, 1'b0);
    rdchk(rtcca_pkg::OFS_IRQ_STAT, 16'h0000);
    // disable, match only sec ones, every other digit differs
    wr(rtcca_pkg::OFS_ALM_CFG, cfg_word(1'b0, 1'b0, 4'h2, rtcca_pkg::RPT_ZERO));
    @(posedge core_clk_in);
    calendar_value_in <= {~cmp[43:4], 4'h5};
    // timer running, update window closed before touching the configuration
    rdchk(rtcca_pkg::OFS_CAL, {1'b1, 2'b00, 1'b0, 4'h0, trim});
    wr(rtcca_pkg::OFS_ALM_CFG, cfg_word(1'b1, 1'b0, 4'h2, rtcca_pkg::RPT_ZERO));
    // single alarm at the next seconds rollover, then the enable drops
    wait_toggle(1'b1, waited);
    chk1(alarm_pulse_out, 1'b0);
    chk1(irq_out, 1'b1);
    rdchk(rtcca_pkg::OFS_ALM_CFG, cfg_word(1'b0, 1'b0, 4'h2, rtcca_pkg::RPT_ZERO));
    rdchk(rtcca_pkg::OFS_IRQ_STAT, 16'h0003);
    chk16(16'(n_half), 16'h0002);
    chk16(16'(n_sec), 16'h0001);
    wrap_up();
  end
endmodule
`default_nettype wire
